// *** rsc_map.svh ***
// Register map, codes and timing constants for the reset source controller.
// Assumes a 40 MHz core clock and a word-aligned AXI4-Lite register window.
`ifndef RSC_MAP_SVH
`define RSC_MAP_SVH
`define RSC_CLK_HZ 40000000
`define RSC_OFS_RSTCTL 4'h0
`define RSC_OFS_FLAGS 4'h4
`define RSC_OFS_LVSEL 4'h8
`define RSC_OFS_STATUS 4'hC
`define RSC_CTRL_IO 8'h55
`define RSC_CTRL_PIN 8'hAA
`define RSC_LV_2V1 8'h55
`define RSC_LV_2V55 8'h33
`define RSC_LV_3V15 8'h99
`define RSC_LV_3V8 8'hAA
`define RSC_BIT_CTRL 3
`define RSC_BIT_LOWV 2
`define RSC_BIT_LVCFG 1
`define RSC_BIT_WDCFG 0
`define RSC_POR_DELAY_MS 50
`define RSC_PIN_DELAY_US 16700
`define RSC_CORRUPT_LOW_SPEED_RC_OSC 3
`define RSC_LOWV_FILTER_CYC 16'h0028
`define RSC_RESP_OKAY 2'h0
`define RSC_RESP_SLVERR 2'h2
`endif

// *** rsc_monitor.sv ***
// Checker for the reset source controller, watching top-level ports only.
// Assumes one core clock domain and an asynchronous active-low reset.
`timescale 1ns/1ps
module rsc_monitor (
  input wire logic i_core_clk, // Core clock
  input wire logic i_nrst, // Reset, active low
  input wire logic i_sleep, // Sleep level
  input wire logic i_wdt_timeout, // Watchdog pulse
  input wire logic i_halt, // Halt pulse
  input wire logic i_clr_wdt, // Clear pulse
  input wire logic o_sys_reset, // Full reset
  input wire logic o_pc_sp_reset, // PC/SP clear
  input wire logic o_por_init, // Power-on init
  input wire logic o_lowv_enable, // Monitor enable
  input wire logic o_timeout_flag, // TO
  input wire logic o_powerdown_flag // POWERDOWN_FLAG
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_wdt_slp;
    i_wdt_timeout && i_sleep && !o_sys_reset;
  endsequence
  sequence s_wdt_run;
    i_wdt_timeout && !i_sleep && !o_sys_reset;
  endsequence
  property p_por_hold;
    $rose(i_nrst) |-> (o_sys_reset && o_por_init && !o_timeout_flag && !o_powerdown_flag)[*8];
  endproperty
  property p_lowv_off;
    i_sleep[*2] |-> !o_lowv_enable;
  endproperty
  property p_lowv_on;
    !i_sleep[*2] |-> o_lowv_enable;
  endproperty
  property p_slp_pulse;
    s_wdt_slp |-> ##[1:3] o_pc_sp_reset;
  endproperty
  property p_slp_keep;
    s_wdt_slp |=> (!o_sys_reset)[*4] ##0 o_timeout_flag;
  endproperty
  property p_wdt_run;
    s_wdt_run |-> ##[1:3] o_sys_reset ##[0:2] o_timeout_flag;
  endproperty
  property p_halt;
    i_halt |-> ##[1:2] o_powerdown_flag;
  endproperty
  property p_clr;
    i_clr_wdt && !i_halt |-> ##[1:2] !o_powerdown_flag;
  endproperty
  property p_one;
    o_pc_sp_reset |=> !o_pc_sp_reset;
  endproperty
  a_por_hold: assert property (p_por_hold)
    else $error("power-on hold too short");
  a_lowv_off: assert property (p_lowv_off)
    else $error("supply monitor on in sleep");
  a_lowv_on: assert property (p_lowv_on)
    else $error("supply monitor off while running");
  a_slp_pulse: assert property (p_slp_pulse)
    else $error("no PC/SP clear on sleep timeout");
  a_slp_keep: assert property (p_slp_keep)
    else $error("sleep timeout gave full reset or no TO");
  a_wdt_run: assert property (p_wdt_run)
    else $error("running timeout without reset and TO");
  a_halt: assert property (p_halt)
    else $error("halt did not set POWERDOWN_FLAG");
  a_clr: assert property (p_clr)
    else $error("clear did not drop POWERDOWN_FLAG");
  a_one: assert property (p_one)
    else $error("PC/SP clear wider than one cycle");
endmodule : rsc_monitor

// *** rsc_partner.sv ***
// Far side: reset RC network on the pin, supply monitor, low-speed oscillator.
// Assumes bench commands change just after core clock edges.
`timescale 1ns/1ps
module rsc_partner (
  input wire logic i_clk, // Core clock, timing only
  input wire logic i_press, // Button held
  input wire logic i_dip, // Supply below threshold
  output logic o_pin_n, // Reset pin level
  output logic o_lowv, // Low-supply indication
  output logic o_osc // Low-speed oscillator
);
  logic [2:0] chg = 3'h0;
  logic [1:0] div = 2'h0;
  initial o_osc = 1'b0;
  // Capacitor recharges slowly, so release is seen late
  always @(posedge i_clk) begin
    chg <= i_press ? 3'h0 : ((chg == 3'h4) ? chg : chg + 3'h1);
    div <= div + 2'h1;
    if (div == 2'h3) o_osc <= !o_osc;
  end
  assign o_pin_n = (chg == 3'h4);
  assign o_lowv = i_dip;
endmodule : rsc_partner

// *** rsc_pkg.sv ***
// Types for the reset source controller.
// Assumes rsc_map.svh is compiled alongside.
package rsc_pkg;
  typedef enum logic [1:0] {RSC_RUN, RSC_HOLD, RSC_PINLOW} rsc_phase_t;
endpackage : rsc_pkg

// *** rsc_reset_ctrl.sv ***
// Reset source controller: reset generation, cause flags, TO/POWERDOWN_FLAG status.
// Assumes core events (halt, clear-watchdog, watchdog overflow) are core-clock pulses;
// pin, low-supply and low-speed oscillator inputs are asynchronous.
`timescale 1ns/1ps
`include "rsc_map.svh"

//
// Contract
// - POR sets port data/direction high, PC zero
// - POR or low-voltage reset holds 50 ms
// - Pin release adds 16.7 ms delay
// - Pin low gives full reset, PC zero
// - Control register 55/AA legal, else reset
// - Control corruption sets flag bit 3
// - Flags set by hardware, cleared by zero-write
// - Flag bits 7..4 read zero
// - Low-voltage reset filtered, always on running
// - Low-voltage reset disabled in power-down
// - Level select has four codes, default 55
// - Bad level code resets, restores default
// - Real low-voltage reset keeps level select
// - Low-voltage reset sets flag bit 2
// - Bad level code sets flag bit 1
// - Watchdog normal timeout: full reset, TO set
// - Watchdog sleep timeout: PC/SP only, TO set
// - TO/POWERDOWN_FLAG values per reset type
// - POR disables irqs, clears watchdog, timers off
// - Bad watchdog enable sets flag bit 0
// - POWERDOWN_FLAG cleared by clear-watchdog, set by halt
module rsc_reset_ctrl
  import rsc_pkg::*;
#(
  parameter int unsigned POR_DELAY_CYC = `RSC_CLK_HZ / 1000 * `RSC_POR_DELAY_MS,
  parameter int unsigned PIN_DELAY_CYC = `RSC_CLK_HZ / 1000 * `RSC_PIN_DELAY_US / 1000
) (
  input wire logic i_core_clk, // 40 MHz core clock
  input wire logic i_nrst, // Power-on reset, active low
  input wire logic i_ext_reset_pin_n, // External reset pin level
  input wire logic i_lowv_detect, // Supply below selected level
  input wire logic i_low_speed_rc_osc, // Low-speed oscillator, sampled
  input wire logic i_wdt_timeout, // Watchdog overflow pulse
  input wire logic i_wdt_cfg_bad, // Watchdog enable field invalid
  input wire logic i_halt, // Halt instruction pulse
  input wire logic i_clr_wdt, // Clear-watchdog instruction pulse
  input wire logic i_sleep, // Core in sleep or idle
  input wire logic [3:0] i_awaddr, // AXI write address
  input wire logic i_awvalid, // AXI write address valid
  output logic o_awready, // AXI write address ready
  input wire logic [31:0] i_wdata, // AXI write data
  input wire logic [3:0] i_wstrb, // AXI write strobes
  input wire logic i_wvalid, // AXI write data valid
  output logic o_wready, // AXI write data ready
  output logic [1:0] o_bresp, // AXI write response
  output logic o_bvalid, // AXI write response valid
  input wire logic i_bready, // AXI write response ready
  input wire logic [3:0] i_araddr, // AXI read address
  input wire logic i_arvalid, // AXI read address valid
  output logic o_arready, // AXI read address ready
  output logic [31:0] o_rdata, // AXI read data
  output logic [1:0] o_rresp, // AXI read response
  output logic o_rvalid, // AXI read data valid
  input wire logic i_rready, // AXI read data ready
  output logic o_sys_reset, // Full system reset, active high
  output logic o_pc_sp_reset, // PC and stack pointer clear pulse
  output logic o_por_init, // Power-on and low-voltage reset init: ports, irqs, timers
  output logic o_lowv_enable, // Low-voltage monitor enable
  output logic [1:0] o_lowv_level, // Selected threshold index
  output logic o_timeout_flag, // TO status flag
  output logic o_powerdown_flag // POWERDOWN_FLAG status flag
);

  typedef struct packed {
    logic [1:0] pin_sync;
    logic [1:0] lv_sync;
    logic [2:0] osc_sync;
    rsc_phase_t phase;
    logic [21:0] hold_cnt;
    logic por_phase;
    logic [15:0] lv_cnt;
    logic [1:0] rc_cnt;
    logic [1:0] lc_cnt;
    logic [7:0] reset_function_ctrl;
    logic [7:0] lowv_level_ctrl;
    logic [3:0] reset_flag_reg;
    logic timeout_flag;
    logic powerdown_flag;
    logic aw_got;
    logic w_got;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic pc_sp_reset;
    logic awready;
    logic wready;
    logic arready;
  } rsc_state_t;

  rsc_state_t st;
  rsc_state_t next_st;

  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------
  function automatic logic lv_code_ok(input logic [7:0] v);
    lv_code_ok = (v == `RSC_LV_2V1) || (v == `RSC_LV_2V55) ||
                 (v == `RSC_LV_3V15) || (v == `RSC_LV_3V8);
  endfunction : lv_code_ok

  function automatic logic [1:0] lv_index(input logic [7:0] v);
    case (v)
      `RSC_LV_2V55: lv_index = 2'h1;
      `RSC_LV_3V15: lv_index = 2'h2;
      `RSC_LV_3V8: lv_index = 2'h3;
      default: lv_index = 2'h0;
    endcase
  endfunction : lv_index

  function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
    merge_byte = s[0] ? d[7:0] : old;
  endfunction : merge_byte

  logic osc_rise;
  logic pin_mode;
  logic pin_low;
  logic lv_event;
  logic rc_fire;
  logic lc_fire;
  logic wdt_full;
  logic any_reset;
  logic do_write;
  logic [3:0] clr_mask;

  // ---------------------------------------------
  // Reset causes
  // ---------------------------------------------
  always_comb begin
    osc_rise = st.osc_sync[1] & ~st.osc_sync[2];
    pin_mode = (st.reset_function_ctrl == `RSC_CTRL_PIN);
    pin_low = pin_mode & ~st.pin_sync[1];
    // Filter counts only while running; power-down stops the monitor
    lv_event = (st.lv_cnt == `RSC_LOWV_FILTER_CYC);
    rc_fire = osc_rise && (st.rc_cnt == 2'(`RSC_CORRUPT_LOW_SPEED_RC_OSC - 1));
    lc_fire = osc_rise && (st.lc_cnt == 2'(`RSC_CORRUPT_LOW_SPEED_RC_OSC - 1));
    wdt_full = i_wdt_timeout & ~i_sleep;
    any_reset = pin_low | lv_event | rc_fire | lc_fire | wdt_full | i_wdt_cfg_bad;
    do_write = st.aw_got && st.w_got && !st.bvalid;
    clr_mask = 4'h0;
    if (do_write && st.aw_addr == `RSC_OFS_FLAGS && st.w_strb[0]) begin
      clr_mask = ~st.w_data[3:0];
    end
  end

  // ---------------------------------------------
  // Next state
  // ---------------------------------------------
  always_comb begin
    next_st = st;
    next_st.pin_sync = {st.pin_sync[0], i_ext_reset_pin_n};
    next_st.lv_sync = {st.lv_sync[0], i_lowv_detect};
    next_st.osc_sync = {st.osc_sync[1:0], i_low_speed_rc_osc};
    next_st.pc_sp_reset = 1'b0;

    // Low-supply filter: short dips never reach the threshold
    if (st.lv_sync[1] && !i_sleep && st.phase == RSC_RUN) begin
      next_st.lv_cnt = (st.lv_cnt == `RSC_LOWV_FILTER_CYC) ? 16'h0000 : st.lv_cnt + 16'h0001;
    end else begin
      next_st.lv_cnt = 16'h0000;
    end

    if (st.reset_function_ctrl == `RSC_CTRL_IO || pin_mode) begin
      next_st.rc_cnt = 2'h0;
    end else if (osc_rise) begin
      next_st.rc_cnt = st.rc_cnt + 2'h1;
    end
    if (lv_code_ok(st.lowv_level_ctrl)) begin
      next_st.lc_cnt = 2'h0;
    end else if (osc_rise) begin
      next_st.lc_cnt = st.lc_cnt + 2'h1;
    end

    // Register writes, bus access
    if (i_awvalid && !st.aw_got) begin
      next_st.aw_got = 1'b1;
      next_st.aw_addr = i_awaddr;
    end
    if (i_wvalid && !st.w_got) begin
      next_st.w_got = 1'b1;
      next_st.w_data = i_wdata;
      next_st.w_strb = i_wstrb;
    end
    if (do_write) begin
      next_st.bvalid = 1'b1;
      next_st.bresp = `RSC_RESP_OKAY;
      case (st.aw_addr)
        `RSC_OFS_RSTCTL: next_st.reset_function_ctrl =
            merge_byte(st.reset_function_ctrl, st.w_data, st.w_strb);
        `RSC_OFS_LVSEL: next_st.lowv_level_ctrl =
            merge_byte(st.lowv_level_ctrl, st.w_data, st.w_strb);
        `RSC_OFS_FLAGS, `RSC_OFS_STATUS: next_st.bresp = `RSC_RESP_OKAY;
        default: next_st.bresp = `RSC_RESP_SLVERR;
      endcase
    end
    if (st.bvalid && i_bready) begin
      next_st.bvalid = 1'b0;
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
    end
    if (i_arvalid && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = `RSC_RESP_OKAY;
      next_st.rdata = 32'h00000000;
      case (i_araddr)
        `RSC_OFS_RSTCTL: next_st.rdata[7:0] = st.reset_function_ctrl;
        `RSC_OFS_FLAGS: next_st.rdata[3:0] = st.reset_flag_reg;
        `RSC_OFS_LVSEL: next_st.rdata[7:0] = st.lowv_level_ctrl;
        `RSC_OFS_STATUS: next_st.rdata[1:0] = {st.timeout_flag, st.powerdown_flag};
        default: next_st.rresp = `RSC_RESP_SLVERR;
      endcase
    end else if (st.rvalid && i_rready) begin
      next_st.rvalid = 1'b0;
    end

    // Flags: hardware set wins over a same-cycle software clear
    next_st.reset_flag_reg = st.reset_flag_reg & ~clr_mask;
    if (rc_fire) begin
      next_st.reset_flag_reg[`RSC_BIT_CTRL] = 1'b1;
      // Reset restores the power-up value, else the corruption reset repeats
      next_st.reset_function_ctrl = `RSC_CTRL_IO;
    end
    if (lv_event) begin
      next_st.reset_flag_reg[`RSC_BIT_LOWV] = 1'b1;
    end
    if (lc_fire) begin
      next_st.reset_flag_reg[`RSC_BIT_LVCFG] = 1'b1;
      next_st.lowv_level_ctrl = `RSC_LV_2V1;
    end
    if (i_wdt_cfg_bad) begin
      next_st.reset_flag_reg[`RSC_BIT_WDCFG] = 1'b1;
    end

    // TO/POWERDOWN_FLAG: pin, low-voltage and corruption resets leave them alone
    if (i_clr_wdt) begin
      next_st.powerdown_flag = 1'b0;
    end
    if (i_halt) begin
      next_st.powerdown_flag = 1'b1;
    end
    if (i_wdt_timeout) begin
      next_st.timeout_flag = 1'b1;
      next_st.pc_sp_reset = i_sleep;
    end

    // Readies kept in flops so the bus outputs need no gate
    next_st.awready = ~next_st.aw_got;
    next_st.wready = ~next_st.w_got;
    next_st.arready = ~next_st.rvalid;

    // Reset hold sequencer
    case (st.phase)
      RSC_RUN: begin
        if (pin_low) begin
          next_st.phase = RSC_PINLOW;
        end else if (any_reset) begin
          next_st.phase = RSC_HOLD;
          next_st.por_phase = lv_event;
          next_st.hold_cnt = 22'(PIN_DELAY_CYC);
          if (lv_event) begin
            next_st.hold_cnt = 22'(POR_DELAY_CYC);
          end
        end
      end
      RSC_PINLOW: begin
        if (st.pin_sync[1]) begin
          next_st.phase = RSC_HOLD;
          next_st.por_phase = 1'b0;
          next_st.hold_cnt = 22'(PIN_DELAY_CYC);
        end
      end
      RSC_HOLD: begin
        if (pin_low) begin
          next_st.phase = RSC_PINLOW;
        end else if (st.hold_cnt <= 22'h000001) begin
          next_st.phase = RSC_RUN;
          next_st.por_phase = 1'b0;
          next_st.hold_cnt = 22'h000000;
        end else begin
          next_st.hold_cnt = st.hold_cnt - 22'h000001;
        end
      end
      default: next_st.phase = RSC_HOLD;
    endcase
  end

  // ---------------------------------------------
  // State register
  // ---------------------------------------------
  // POR starts in the hold phase so the start-up delay runs first
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st <= '0;
      st.pin_sync <= 2'h3;
      st.phase <= RSC_HOLD;
      st.hold_cnt <= 22'(POR_DELAY_CYC);
      st.por_phase <= 1'b1;
      st.reset_function_ctrl <= `RSC_CTRL_IO;
      st.lowv_level_ctrl <= `RSC_LV_2V1;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------
  // Outputs
  // ---------------------------------------------
  logic sys_reset_q;
  logic por_init_q;
  logic lowv_en_q;
  logic [1:0] lowv_lvl_q;
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sys_reset_q <= 1'b1;
      por_init_q <= 1'b1;
      // Monitor armed from power-up; no gap before the first clock
      lowv_en_q <= 1'b1;
      lowv_lvl_q <= 2'h0;
    end else begin
      sys_reset_q <= (next_st.phase != RSC_RUN);
      por_init_q <= next_st.por_phase & (next_st.phase != RSC_RUN);
      lowv_en_q <= ~i_sleep;
      lowv_lvl_q <= lv_index(next_st.lowv_level_ctrl);
    end
  end

  assign o_awready = st.awready;
  assign o_wready = st.wready;
  assign o_bvalid = st.bvalid;
  assign o_bresp = st.bresp;
  assign o_arready = st.arready;
  assign o_rvalid = st.rvalid;
  assign o_rdata = st.rdata;
  assign o_rresp = st.rresp;
  assign o_sys_reset = sys_reset_q;
  assign o_pc_sp_reset = st.pc_sp_reset;
  assign o_por_init = por_init_q;
  assign o_lowv_enable = lowv_en_q;
  assign o_lowv_level = lowv_lvl_q;
  assign o_timeout_flag = st.timeout_flag;
  assign o_powerdown_flag = st.powerdown_flag;

endmodule : rsc_reset_ctrl

// *** rsc_reset_ctrl_test.sv ***
// Self-checking bench for the reset source controller.
// Assumes rsc_map.svh, the design, the partner and the checker are compiled first.
`timescale 1ns/1ps
`include "rsc_map.svh"
module rsc_reset_ctrl_test;
  logic i_core_clk = 1'b0, i_nrst = 1'b0, press = 1'b0, dip = 1'b0;
  logic i_wdt_timeout = 1'b0, i_wdt_cfg_bad = 1'b0, i_halt = 1'b0, i_clr_wdt = 1'b0;
  logic i_sleep = 1'b0, i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
  logic i_arvalid = 1'b0, i_rready = 1'b0;
  logic [3:0] i_awaddr = 4'h0, i_araddr = 4'h0, i_wstrb = 4'hF;
  logic [31:0] i_wdata = 32'h0, o_rdata, rv;
  logic ext_n, lowv, osc, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic o_sys_reset, o_pc_sp_reset, o_por_init, o_lowv_enable, o_timeout_flag, o_powerdown_flag;
  logic [1:0] o_bresp, o_rresp, o_lowv_level, rs, bs;
  logic [7:0] codes [4] = '{8'h55, 8'h33, 8'h99, 8'hAA};
  int fail_count = 0, n_tests = 0, cyc = 0, n = 0;
  always #12.5 i_core_clk = ~i_core_clk;
  rsc_reset_ctrl #(.POR_DELAY_CYC(20), .PIN_DELAY_CYC(10)) rsc_reset_ctrl_i (
    .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_ext_reset_pin_n(ext_n), .i_lowv_detect(lowv),
    .i_low_speed_rc_osc(osc), .i_wdt_timeout(i_wdt_timeout), .i_wdt_cfg_bad(i_wdt_cfg_bad),
    .i_halt(i_halt), .i_clr_wdt(i_clr_wdt), .i_sleep(i_sleep), .i_awaddr(i_awaddr),
    .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
    .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
    .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
    .o_sys_reset(o_sys_reset), .o_pc_sp_reset(o_pc_sp_reset), .o_por_init(o_por_init),
    .o_lowv_enable(o_lowv_enable), .o_lowv_level(o_lowv_level),
    .o_timeout_flag(o_timeout_flag), .o_powerdown_flag(o_powerdown_flag));
  rsc_partner rsc_partner_i (.i_clk(i_core_clk), .i_press(press), .i_dip(dip),
    .o_pin_n(ext_n), .o_lowv(lowv), .o_osc(osc));
  task automatic tick(input int k);
    repeat (k) @(posedge i_core_clk);
  endtask : tick
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wt(input logic lvl);
    n = 0;
    while (o_sys_reset !== lvl && n < 300) begin
      tick(1);
      n++;
    end
    chk(o_sys_reset, lvl); // A wait that runs out counts as a mismatch
  endtask : wt
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_awaddr <= a;
    i_wdata <= {24'h0, d};
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do begin
      tick(1);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
    end while (o_bvalid !== 1'b1);
    bs = o_bresp;
    i_bready <= 1'b0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [3:0] a);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do begin
      tick(1);
      if (o_arready) i_arvalid <= 1'b0;
    end while (o_rvalid !== 1'b1);
    rv = o_rdata;
    rs = o_rresp;
    i_rready <= 1'b0;
    tick(1);
  endtask : rd
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd(`RSC_OFS_RSTCTL); chk(rv, 32'h55);
    rd(`RSC_OFS_LVSEL); chk(rv, 32'h55);
    rd(`RSC_OFS_FLAGS); chk(rv, 32'h0);
    rd(4'h6); chk(rs, `RSC_RESP_SLVERR);
    wr(4'h6, 8'h00); chk(bs, `RSC_RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      wr(`RSC_OFS_LVSEL, codes[i]); chk(bs, `RSC_RESP_OKAY);
      tick(1); chk(o_lowv_level, i);
      rd(`RSC_OFS_LVSEL); chk(rv, codes[i]);
    end
    // Byte strobe off: the write must leave the register alone
    i_wstrb <= 4'h0; wr(`RSC_OFS_LVSEL, 8'h55); i_wstrb <= 4'hF;
    rd(`RSC_OFS_LVSEL); chk(rv, 32'hAA);
  endtask : t_regs
  task automatic t_lowv;
    dip <= 1'b1; tick(20); dip <= 1'b0; tick(60); chk(o_sys_reset, 1'b0);
    dip <= 1'b1; wt(1); chk(o_por_init, 1'b1);
    dip <= 1'b0; wt(0); chk(n > 19, 1'b1);
    rd(`RSC_OFS_LVSEL); chk(rv, 32'hAA);
    rd(`RSC_OFS_FLAGS); chk(rv, 32'h4);
    chk({o_timeout_flag, o_powerdown_flag}, 2'h0);
    wr(`RSC_OFS_FLAGS, 8'h00);
    i_sleep <= 1'b1; dip <= 1'b1; tick(80); chk(o_sys_reset, 1'b0);
    dip <= 1'b0; i_sleep <= 1'b0; tick(3);
  endtask : t_lowv
  task automatic t_corrupt;
    wr(`RSC_OFS_LVSEL, 8'h5A); wt(1); chk((n > 8) && (n < 40), 1'b1);
    wt(0); rd(`RSC_OFS_LVSEL); chk(rv, 32'h55);
    wr(`RSC_OFS_RSTCTL, 8'h12); wt(1); chk(o_sys_reset, 1'b1);
    wt(0); rd(`RSC_OFS_FLAGS); chk(rv, 32'hA);
    rd(`RSC_OFS_RSTCTL); chk(rv, 32'h55);
    wr(`RSC_OFS_FLAGS, 8'h08); rd(`RSC_OFS_FLAGS); chk(rv, 32'h8);
    i_wdt_cfg_bad <= 1'b1; tick(1); i_wdt_cfg_bad <= 1'b0; wt(1); wt(0);
    rd(`RSC_OFS_FLAGS); chk(rv, 32'h9);
    wr(`RSC_OFS_FLAGS, 8'h00); rd(`RSC_OFS_FLAGS); chk(rv, 32'h0);
  endtask : t_corrupt
  task automatic t_pin;
    wr(`RSC_OFS_RSTCTL, `RSC_CTRL_IO);
    press <= 1'b1; tick(12); chk(o_sys_reset, 1'b0);
    press <= 1'b0; tick(8); wr(`RSC_OFS_RSTCTL, `RSC_CTRL_PIN);
    press <= 1'b1; wt(1); tick(30); chk(o_sys_reset, 1'b1);
    press <= 1'b0; wt(0); chk((n > 13) && (n < 30), 1'b1);
    chk({o_timeout_flag, o_powerdown_flag}, 2'h0);
    wr(`RSC_OFS_RSTCTL, `RSC_CTRL_IO);
  endtask : t_pin
  task automatic t_wdt;
    i_halt <= 1'b1; tick(1); i_halt <= 1'b0; tick(2); chk(o_powerdown_flag, 1'b1);
    i_sleep <= 1'b1; tick(2); i_wdt_timeout <= 1'b1; tick(1); i_wdt_timeout <= 1'b0; tick(4);
    chk(o_sys_reset, 1'b0);
    rd(`RSC_OFS_STATUS); chk(rv, 32'h3);
    i_sleep <= 1'b0; i_clr_wdt <= 1'b1; tick(1); i_clr_wdt <= 1'b0; tick(2);
    chk(o_powerdown_flag, 1'b0);
    i_wdt_timeout <= 1'b1; tick(1); i_wdt_timeout <= 1'b0; wt(1); wt(0);
    rd(`RSC_OFS_STATUS); chk(rv, 32'h2);
  endtask : t_wdt
  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end
  initial begin
    tick(20);
    chk({o_sys_reset, o_por_init}, 2'h3);
    chk({o_timeout_flag, o_powerdown_flag}, 2'h0);
    i_nrst <= 1'b1;
    wt(0); chk(n > 19, 1'b1);
    t_regs();
    t_lowv();
    t_corrupt();
    t_pin();
    t_wdt();
    results();
  end
endmodule : rsc_reset_ctrl_test
bind rsc_reset_ctrl rsc_monitor rsc_monitor_i (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
  .i_sleep(i_sleep), .i_wdt_timeout(i_wdt_timeout), .i_halt(i_halt), .i_clr_wdt(i_clr_wdt),
  .o_sys_reset(o_sys_reset), .o_pc_sp_reset(o_pc_sp_reset), .o_por_init(o_por_init),
  .o_lowv_enable(o_lowv_enable), .o_timeout_flag(o_timeout_flag),
  .o_powerdown_flag(o_powerdown_flag));
